//--- srap_pkg.sv
package srap_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int HDR_BITS = 5;                 // direction and byte count field
  localparam int ADDR_BITS = 11;               // register address field
  localparam int DATA_BITS = 8;                // data byte field
  localparam int CMD_BITS = HDR_BITS + ADDR_BITS;       // 16-bit command word
  localparam int FRAME_BITS = CMD_BITS + DATA_BITS;     // 24-bit frame

  // positions inside the 16-bit command word, msb arrives first
  localparam int CMD_RW_POS = 15;              // 1 = read, 0 = write
  localparam int CMD_CNT_MSB = 14;             // byte count field top bit
  localparam int CMD_CNT_LSB = 11;             // byte count field bottom bit
  localparam int CMD_ADDR_MSB = 10;            // address field top bit

  // ----------------------------------------------------------------
  // bit counter marks (count of rising sclk edges taken so far)
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_CMD_LAST = 5'h0f;   // edge that completes the command word
  localparam logic [4:0] CNT_DATA_FIRST = 5'h10; // first data bit of a byte
  localparam logic [4:0] CNT_DATA_LAST = 5'h17;  // edge that completes a data byte

  // ----------------------------------------------------------------
  // synchroniser layout and reset values
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5;                   // sclk, cs_n, sdi, sdio, three_wire
  localparam int SY_SCLK = 0;                  // serial clock lane
  localparam int SY_CS_N = 1;                  // chip select lane
  localparam int SY_SDI = 2;                   // 4-wire input data lane
  localparam int SY_SDIO = 3;                  // shared data lane
  localparam int SY_3W = 4;                    // wiring mode lane
  localparam logic [4:0] SYNC_RST = 5'h02;     // cs_n idles high, the rest low

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ = 50_000_000;     // core clock rate

  // frame sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA
  } srap_state_e;

endpackage

//--- srap_sync.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// two-stage synchroniser for pins from outside the core clock domain
// ------------------------------------------------------------------
module srap_sync #(
  parameter int WIDTH = 1,                    // number of lanes
  parameter logic [WIDTH-1:0] RST_VAL = '0    // value held under reset
) (
  input wire logic clk_in,                    // core clock
  input wire logic rst_in,                    // synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in,      // raw pin levels
  output logic [WIDTH-1:0] sync_out           // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;   // first stage, read only by second stage
  logic [WIDTH-1:0] meta_next;  // first stage next value
  logic [WIDTH-1:0] sync_reg;   // second stage
  logic [WIDTH-1:0] sync_next;  // second stage next value

  // next values of both stages
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // stage registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule // srap_sync

//--- srap_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - supports 4-wire and 3-wire bidirectional wiring
// - write frame is header, address, data: 24
// - five-bit leading field gives direction, byte count
// - next eleven bits select the target register
// - last eight bits written into addressed register
// - read byte returned on output or shared line

module srap_top #(
  parameter int ADDR_W = srap_pkg::ADDR_BITS,   // register address width
  parameter int DATA_W = srap_pkg::DATA_BITS,   // register data width
  parameter int DEPTH = 2 ** ADDR_W             // number of registers
) (
  input wire logic core_clk_in,                 // core clock, 50 MHz
  input wire logic rst_in,                      // synchronous reset, active high
  input wire logic sclk_in,                     // serial clock from the master
  input wire logic cs_n_in,                     // chip select, active low
  input wire logic sdi_in,                      // 4-wire serial input data
  input wire logic sdio_in,                     // shared data line, input side
  input wire logic three_wire_in,               // 1 = 3-wire, 0 = 4-wire wiring
  output logic serial_data_out,                 // 4-wire serial output data
  output logic serial_data_oe_out,              // drive enable for serial_data_out
  output logic sdio_out,                        // shared data line, output side
  output logic sdio_oe_out,                     // drive enable for the shared line
  output logic wr_strobe_out,                   // one-cycle pulse per stored byte
  output logic [ADDR_W-1:0] wr_addr_out,        // address of the stored byte
  output logic [DATA_W-1:0] wr_data_out,        // value of the stored byte
  output logic [3:0] byte_count_out,            // byte count of the current frame
  input wire logic [ADDR_W-1:0] rd_addr_in,     // core-side register read address
  output logic [DATA_W-1:0] rd_data_out         // core-side register read data
);

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [srap_pkg::SYNC_W-1:0] pins_async;  // raw pin lanes
  logic [srap_pkg::SYNC_W-1:0] pins_s;      // synchronised pin lanes
  logic sclk_d_reg;                         // previous synchronised sclk
  logic sclk_d_next;                        // next previous sclk
  logic sclk_rise;                          // sclk rising edge seen
  logic sclk_fall;                          // sclk falling edge seen
  logic cs_idle;                            // chip select inactive
  logic three_wire;                         // synchronised wiring mode
  logic mosi;                               // selected incoming data bit

  assign pins_async = {three_wire_in, sdio_in, sdi_in, cs_n_in, sclk_in};

  // every pin passes two flip-flops before use
  srap_sync #(
    .WIDTH(srap_pkg::SYNC_W),
    .RST_VAL(srap_pkg::SYNC_RST)
  ) u_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pins_async),
    .sync_out(pins_s)
  );

  assign cs_idle = pins_s[srap_pkg::SY_CS_N];
  assign three_wire = pins_s[srap_pkg::SY_3W];
  // incoming data: shared line in 3-wire, dedicated input in 4-wire
  assign mosi = three_wire ? pins_s[srap_pkg::SY_SDIO] : pins_s[srap_pkg::SY_SDI];
  assign sclk_rise = pins_s[srap_pkg::SY_SCLK] & ~sclk_d_reg;
  assign sclk_fall = ~pins_s[srap_pkg::SY_SCLK] & sclk_d_reg;

  // ----------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] regs_mem [DEPTH];      // control registers
  logic [ADDR_W-1:0] mem_rd_ptr;            // serial-side read pointer
  logic [DATA_W-1:0] mem_rd_data;           // serial-side read data
  logic mem_we;                             // store one byte this cycle
  logic [ADDR_W-1:0] mem_wa;                // store address
  logic [DATA_W-1:0] mem_wd;                // store data
  logic [DATA_W-1:0] rd_data_reg;           // core-side read data register

  assign mem_rd_data = regs_mem[mem_rd_ptr];

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  srap_pkg::srap_state_e state_reg;         // frame phase
  srap_pkg::srap_state_e state_next;        // next frame phase
  logic [4:0] cnt_reg;                      // rising edges taken in frame
  logic [4:0] cnt_next;                     // next edge count
  logic [srap_pkg::CMD_BITS-2:0] hdr_reg;   // command bits gathered so far
  logic [srap_pkg::CMD_BITS-2:0] hdr_next;  // next command bits
  logic [srap_pkg::CMD_BITS-1:0] cmd_word;  // command word with the newest bit
  logic rw_reg;                             // 1 = read frame
  logic rw_next;                            // next direction
  logic [3:0] count_reg;                    // byte count field
  logic [3:0] count_next;                   // next byte count
  logic [ADDR_W-1:0] addr_reg;              // current register address
  logic [ADDR_W-1:0] addr_next;             // next register address
  logic [DATA_W-1:0] rx_reg;                // incoming data byte
  logic [DATA_W-1:0] rx_next;               // next incoming byte
  logic [DATA_W-1:0] rx_byte;               // byte with the newest bit
  logic [DATA_W-1:0] tx_reg;                // outgoing data byte
  logic [DATA_W-1:0] tx_next;               // next outgoing byte
  logic out_reg;                            // bit on the output pins
  logic out_next;                           // next output bit
  logic drive_reg;                          // read data being driven
  logic drive_next;                         // next drive state
  logic wr_stb_next;                        // next write pulse
  logic wr_stb_reg;                         // write pulse register
  logic [ADDR_W-1:0] wr_addr_reg;           // reported write address
  logic [DATA_W-1:0] wr_data_reg;           // reported write data

  // msb arrives first, so the newest bit lands at the bottom
  assign cmd_word = {hdr_reg, mosi};
  assign rx_byte = {rx_reg[DATA_W-2:0], mosi};

  // ----------------------------------------------------------------
  // next-state logic of the frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    sclk_d_next = pins_s[srap_pkg::SY_SCLK];
    state_next = state_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    rw_next = rw_reg;
    count_next = count_reg;
    addr_next = addr_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    out_next = out_reg;
    drive_next = drive_reg;
    wr_stb_next = 1'b0;
    mem_we = 1'b0;
    mem_wa = addr_reg;
    mem_wd = rx_byte;
    // lookup for the first byte, then the following address when streaming
    mem_rd_ptr = (state_reg == srap_pkg::ST_CMD) ?
                 cmd_word[srap_pkg::CMD_ADDR_MSB:0] : addr_reg + ADDR_W'(1);
    if (cs_idle) begin
      // select inactive: frame aborted, clock edges ignored, line released
      state_next = srap_pkg::ST_IDLE;
      cnt_next = '0;
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        // select just asserted: start a fresh frame
        srap_pkg::ST_IDLE: begin
          state_next = srap_pkg::ST_CMD;
          cnt_next = '0;
          hdr_next = '0;
        end
        // gather the leading field and the address
        srap_pkg::ST_CMD: begin
          if (sclk_rise) begin
            hdr_next = cmd_word[srap_pkg::CMD_BITS-2:0];
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == srap_pkg::CNT_CMD_LAST) begin
              // decode direction and byte count from the leading field
              rw_next = cmd_word[srap_pkg::CMD_RW_POS];
              count_next = cmd_word[srap_pkg::CMD_CNT_MSB:srap_pkg::CMD_CNT_LSB];
              addr_next = cmd_word[srap_pkg::CMD_ADDR_MSB:0];
              tx_next = mem_rd_data;
              state_next = srap_pkg::ST_DATA;
            end
          end
        end
        // data byte: shift in for writes, shift out for reads
        srap_pkg::ST_DATA: begin
          if (sclk_rise) begin
            rx_next = rx_byte;
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == srap_pkg::CNT_DATA_LAST) begin
              // frame bit 24 taken; further bytes go to the next address
              cnt_next = srap_pkg::CNT_DATA_FIRST;
              addr_next = addr_reg + ADDR_W'(1);
              if (rw_reg) begin
                tx_next = mem_rd_data;
              end else begin
                mem_we = 1'b1;
                wr_stb_next = 1'b1;
              end
            end
          end else if (sclk_fall && rw_reg) begin
            // present the next read bit after each falling edge
            out_next = tx_reg[DATA_W-1];
            tx_next = {tx_reg[DATA_W-2:0], 1'b0};
            drive_next = 1'b1;
          end
        end
        default: begin
          state_next = srap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sclk_d_reg <= 1'b0;
      state_reg <= srap_pkg::ST_IDLE;
      cnt_reg <= '0;
      hdr_reg <= '0;
      rw_reg <= 1'b0;
      count_reg <= '0;
      addr_reg <= '0;
      rx_reg <= '0;
      tx_reg <= '0;
      out_reg <= 1'b0;
      drive_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
      rw_reg <= rw_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      out_reg <= out_next;
      drive_reg <= drive_next;
      wr_stb_reg <= wr_stb_next;
      if (mem_we) begin
        wr_addr_reg <= mem_wa;
        wr_data_reg <= mem_wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // register array: serial write port and core-side read port
  // ----------------------------------------------------------------
  // registers clear under reset, so a streamed read that runs past the
  // written addresses shifts out zeros instead of unknown bits
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        regs_mem[i] <= '0;
      end
      rd_data_reg <= '0;
    end else begin
      if (mem_we) begin
        regs_mem[mem_wa] <= mem_wd;
      end
      rd_data_reg <= regs_mem[rd_addr_in];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read data goes to the dedicated output in 4-wire, shared line in 3-wire
  assign serial_data_out = out_reg;
  assign sdio_out = out_reg;
  assign serial_data_oe_out = drive_reg & ~three_wire;
  assign sdio_oe_out = drive_reg & three_wire;
  assign wr_strobe_out = wr_stb_reg;
  assign wr_addr_out = wr_addr_reg;
  assign wr_data_out = wr_data_reg;
  assign byte_count_out = count_reg;
  assign rd_data_out = rd_data_reg;

endmodule // srap_top

//--- srap_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker for the serial register access port
// ----------------------------------------------------------------
module srap_props #(
  parameter int ADDR_W = 11, // register address width
  parameter int DATA_W = 8   // register data width
) (
  input wire logic core_clk_in,              // core clock
  input wire logic rst_in,                   // synchronous reset
  input wire logic cs_n_in,                  // chip select, active low
  input wire logic three_wire_in,            // wiring mode
  input wire logic serial_data_out,          // 4-wire read bit
  input wire logic serial_data_oe_out,       // 4-wire drive enable
  input wire logic sdio_out,                 // shared line read bit
  input wire logic sdio_oe_out,              // shared line drive enable
  input wire logic wr_strobe_out,            // stored byte pulse
  input wire logic [ADDR_W-1:0] wr_addr_out, // stored address
  input wire logic [DATA_W-1:0] wr_data_out, // stored value
  input wire logic [3:0] byte_count_out      // frame byte count
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_oe_excl; !(sdio_oe_out && serial_data_oe_out); endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both drive enables high");
  property p_oe_3w; sdio_oe_out |-> three_wire_in; endproperty
  a_oe_3w: assert property (p_oe_3w) else $error("shared line driven in 4-wire");
  property p_oe_4w; serial_data_oe_out |-> !three_wire_in; endproperty
  a_oe_4w: assert property (p_oe_4w) else $error("output line driven in 3-wire");
  property p_same_bit; serial_data_out == sdio_out; endproperty
  a_same_bit: assert property (p_same_bit) else $error("read bits differ");
  property p_strobe_pulse; wr_strobe_out |=> !wr_strobe_out; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_hold; !wr_strobe_out |-> $stable(wr_addr_out) && $stable(wr_data_out); endproperty
  a_hold: assert property (p_hold) else $error("write result moved");
  property p_strobe_in_frame; wr_strobe_out |-> !$past(cs_n_in, 3); endproperty
  a_strobe_in_frame: assert property (p_strobe_in_frame) else $error("strobe outside frame");
  property p_oe_drop; $rose(cs_n_in) |-> ##[1:5] !(sdio_oe_out || serial_data_oe_out); endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("drive kept after deselect");
  property p_idle_quiet; cs_n_in [*5] |-> !sdio_oe_out && !serial_data_oe_out && !wr_strobe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while deselected");
  property p_bc_hold; cs_n_in [*5] |=> $stable(byte_count_out); endproperty
  a_bc_hold: assert property (p_bc_hold) else $error("byte count moved while idle");
endmodule // srap_props

bind srap_top srap_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
  .three_wire_in(three_wire_in), .serial_data_out(serial_data_out),
  .serial_data_oe_out(serial_data_oe_out), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
  .wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
  .byte_count_out(byte_count_out)
);

//--- srap_master_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// serial bus master model, changes pins at the core falling edge
// ----------------------------------------------------------------
module srap_master_model (
  input wire logic clk_in,       // core clock, paces the link
  input wire logic dout_line_in, // resolved 4-wire return line
  input wire logic sdio_line_in, // resolved shared line
  output logic sclk_out,         // serial clock, still outside frames unless noise clocks are requested
  output logic cs_n_out,         // chip select, active low
  output logic sdi_out,          // 4-wire data to the device
  output logic sdio_out,         // shared line drive value
  output logic sdio_oe_out       // shared line drive enable
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    sdio_out = 1'b0;
    sdio_oe_out = 1'b0;
  end

  // one frame, msb first; nbits below 24 aborts; noise clocks while deselected
  task automatic xfer(input logic three, input logic [15:0] cmd, input logic [7:0] wd,
                      input int nbits, input logic noise, output logic [7:0] rd);
    logic [23:0] f;
    f = {cmd, wd};
    rd = '0;
    if (noise) begin
      repeat (8) begin
        sdi_out = ~sdi_out;
        sclk_out = ~sclk_out;
        repeat (4) @(negedge clk_in);
      end
    end
    cs_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = 23; i >= 24 - nbits; i--) begin
      if (i >= 8 || !cmd[15]) begin
        sdi_out = f[i];
        sdio_out = f[i];
        sdio_oe_out = three;
      end else begin
        sdi_out = ~sdi_out;
        sdio_oe_out = 1'b0;
      end
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      if (cmd[15] && i < 8) begin
        rd[i] = three ? sdio_line_in : dout_line_in;
      end
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    cs_n_out = 1'b1;
    sdio_oe_out = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask
endmodule // srap_master_model

//--- tb_top.sv
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk_in = 1'b0;    // 50 MHz core clock
  logic rst_in = 1'b1;         // synchronous reset
  logic three_wire_in = 1'b0;  // wiring mode
  logic [10:0] rd_addr_in = '0; // core read address
  logic sclk, cs_n, sdi, m_sdio, m_oe; // master pins
  logic serial_data_out, serial_data_oe_out, sdio_out, sdio_oe_out, wr_strobe_out;
  logic [10:0] wr_addr_out;
  logic [7:0] wr_data_out, rd_data_out;
  logic [3:0] byte_count_out;
  wire dout_w = serial_data_oe_out ? serial_data_out : ~serial_data_out; // released: inverse
  wire sdio_w = sdio_oe_out ? sdio_out : (m_oe ? m_sdio : ~sdio_out);
  int fails = 0;
  int check_count = 0;
  int n_strobe = 0;

  always #10 core_clk_in = ~core_clk_in;

  srap_top dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .sdi_in(sdi), .sdio_in(sdio_w), .three_wire_in(three_wire_in),
    .serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
    .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out), .wr_strobe_out(wr_strobe_out),
    .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .byte_count_out(byte_count_out),
    .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out));

  srap_master_model u_master (.clk_in(core_clk_in), .dout_line_in(dout_w),
    .sdio_line_in(sdio_w), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdio_out(m_sdio), .sdio_oe_out(m_oe));

  // counts stored bytes
  always @(posedge core_clk_in) if (wr_strobe_out === 1'b1) n_strobe <= n_strobe + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge core_clk_in);
    fails++;
    final_report;
  end

  // ----------------------------------------------------------------
  // write, read back, abort, core read, in both wirings
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] seed;
    logic [10:0] a;
    logic [7:0] d, r;
    logic [3:0] c;
    int s0;
    seed = 32'h0000_8c80;
    repeat (5) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (int m = 0; m < 2; m++) begin
      three_wire_in = m[0];
      repeat (6) @(negedge core_clk_in);
      for (int k = 0; k < 6; k++) begin
        seed = xs(seed);
        a = (k == 0) ? 11'h000 : (k == 1) ? 11'h7ff : seed[10:0];
        d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : seed[18:11];
        c = seed[22:19];
        s0 = n_strobe;
        u_master.xfer(m[0], {1'b0, c, a}, d, 24, 1'b0, r);
        check("strobe count", n_strobe, s0 + 1);
        check("write address", wr_addr_out, a);
        check("write data", wr_data_out, d);
        check("byte count", byte_count_out, c);
        u_master.xfer(m[0], {1'b1, c, a}, ~d, 24, 1'b0, r);
        check("read byte", r, d);
        u_master.xfer(m[0], {1'b0, c, a}, ~d, 16 + k, 1'b1, r);
        check("aborted frame", n_strobe, s0 + 1);
        rd_addr_in = a;
        repeat (2) @(negedge core_clk_in);
        check("core read", rd_data_out, d);
      end
    end
    final_report;
  end
endmodule // tb_top
